// *** src/qsbl_pkg.sv ***
// qsbl_pkg: constants, states and carriers of the quad serial boot loader
// assumes a quad-line serial flash that takes commands on four lines
package qsbl_pkg;

  // strap patterns, sampled once after power-on
  localparam logic [2:0]  STRAP_AS_FAST = 3'h1;
  localparam logic [2:0]  STRAP_AS_NORM = 3'h3;
  localparam logic [2:0]  STRAP_JTAG    = 3'h7;
  localparam int          STRAP_WAIT    = 3;

  // flash commands
  localparam logic [7:0]  CMD_READ      = 8'h0B;
  localparam logic [7:0]  CMD_EN4B      = 8'hB7;

  // firmware section boundaries
  localparam logic [31:0] FW_BASE_0     = 32'h0000_0000;
  localparam logic [31:0] FW_BASE_1     = 32'h0004_0000;
  localparam logic [31:0] FW_BASE_2     = 32'h0008_0000;
  localparam logic [31:0] FW_BASE_3     = 32'h000C_0000;
  localparam int          FLASH_4B_MBIT = 256;

  // nibble counts of the header of one command
  localparam logic [3:0]  CMD_NIBS      = 4'h2;
  localparam logic [3:0]  ADDR3_NIBS    = 4'h8;
  localparam logic [3:0]  ADDR4_NIBS    = 4'hA;

  // one beat of the serial clock is four system cycles
  localparam logic [1:0]  PH_DRIVE      = 2'h0;
  localparam logic [1:0]  PH_RISE       = 2'h2;
  localparam logic [1:0]  PH_SAMPLE     = 2'h3;

  typedef enum {
    ST_STRAP, ST_HIZ, ST_FW_GO, ST_FW_RD, ST_EN4_GO, ST_EN4_WT,
    ST_BS_GO, ST_BS_RD, ST_DRAIN, ST_USER, ST_FWD, ST_FAIL
  } qsbl_state_t;

  typedef struct packed {
    logic       sclk;
    logic [3:0] dq;
    logic [3:0] dq_oe;
    logic [3:0] cs_n;
    logic [3:0] cs_oe;
  } qsbl_pins_t;

  typedef struct packed {
    logic [2:0] strap;
    logic [3:0] dq;
    logic       helper;
    logic       frame;
    logic       req;
  } qsbl_async_t;

endpackage

// *** src/qsbl_loader.sv ***
// qsbl_loader: quad serial flash boot loader with its stream FIFO
// assumes one boot flash on select 0, up to three more on selects 1..3,
// a programmer link on its own clock, and a consumer of the bitstream
//
// Functional notes
// - JTAG strap tristates flash clock, four data lines and four selects.
// - One boot flash plus three more, own selects, shared clock and data.
// - Straps are mode only at power-on, then become select outputs except in JTAG mode.
// - Firmware is read with three-byte addresses.
// - After firmware, flashes of 256 Mb or more switch to four-byte mode.
// - Firmware sections are sought at 0, 256k, 512k and 768k.
// - With helper loaded, link bytes are forwarded to the boot flash.
// - Single flash: select 0 low when used, selects 1..3 held high until user mode, then follow USER_CS_N.
// - Configuration done rises only after the whole bitstream arrived.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
module qsbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
)(
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // qsbl_fifo

////////////////////////////////////////////////////////////////////////////
module qsbl_loader
  import qsbl_pkg::*;
#(
  parameter int         FW_BYTES    = 16,
  parameter int         BS_BYTES    = 64,
  parameter int         DUMMY_BEATS = 4,
  parameter int         FLASH_MBIT  = 256,
  parameter int         FIFO_DEPTH  = 32,
  parameter logic [7:0] FW_MAGIC    = 8'hA5
)(
  input  wire logic       SYS_CLK,
  input  wire logic       RST_B,
  output logic            FLASH_CLK,
  output logic            FLASH_CLK_OE,
  input  wire logic [3:0] FLASH_DQ_IN,
  output logic      [3:0] FLASH_DQ_OUT,
  output logic      [3:0] FLASH_DQ_OE,
  output logic      [3:0] FLASH_CS_N,
  output logic      [3:0] FLASH_CS_OE,
  input  wire logic [2:0] STRAP_IN,
  input  wire logic [2:0] USER_CS_N,
  input  wire logic       HELPER_OK,
  output logic            CONF_DONE,
  output logic            CONF_ERR,
  output logic      [7:0] CFG_DATA,
  output logic            CFG_VALID,
  input  wire logic       CFG_READY,
  input  wire logic       LINK_CLK,
  input  wire logic       LINK_FRAME,
  input  wire logic       LINK_DATA,
  output logic            LINK_READY
);

  qsbl_state_t  state;
  qsbl_pins_t   pins;
  qsbl_async_t  sy1;
  qsbl_async_t  sy;
  logic [1:0]   strap_cnt;
  logic         strap_done;
  logic         jtag_mode;
  logic [1:0]   fw_idx;
  logic         fw_ok;
  logic         first;
  logic         ok_now;
  logic         a4;
  logic         op_go;
  logic [7:0]   op_cmd;
  logic [31:0]  op_addr;
  logic         op_raw;
  logic         op_a4;
  logic [15:0]  op_rd;
  logic [1:0]   ph;
  logic         e_busy;
  logic         e_done;
  logic         e_hold;
  logic         e_last;
  logic [39:0]  sreg;
  logic [3:0]   tx_cnt;
  logic [7:0]   dm_cnt;
  logic [15:0]  rx_cnt;
  logic [3:0]   rx_hi;
  logic [7:0]   rx_byte;
  logic         byte_v;
  logic         gap_ok;
  logic         fifo_in_valid;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [7:0]   fifo_out_data;
  logic         ack;
  logic [6:0]   lk_shift;
  logic [2:0]   lk_bcnt;
  logic [7:0]   lk_hold;
  logic         lk_req;
  logic         lk_ack_s1;
  logic         lk_ack_s2;
  logic         clk_oe;

  function automatic logic [31:0] fw_base(input logic [1:0] idx);
    case (idx)
      2'h0:    fw_base = FW_BASE_0;
      2'h1:    fw_base = FW_BASE_1;
      2'h2:    fw_base = FW_BASE_2;
      default: fw_base = FW_BASE_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for pins and the link request
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sy1 <= '0;
      sy  <= '0;
    end else begin
      sy1 <= {STRAP_IN, FLASH_DQ_IN, HELPER_OK, LINK_FRAME, lk_req};
      sy  <= sy1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // beat engine: command, address, dummy beats, read nibbles
  assign e_last = (tx_cnt == 4'h1 && dm_cnt == '0 && rx_cnt == '0)
               || (tx_cnt == '0 && dm_cnt == 8'h01 && rx_cnt == '0)
               || (tx_cnt == '0 && dm_cnt == '0 && rx_cnt == 16'h0001);
  assign e_hold = state == ST_BS_RD && !fifo_in_ready && ph == PH_DRIVE
               && tx_cnt == '0 && dm_cnt == '0 && rx_cnt != '0;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ph      <= PH_DRIVE;
      e_busy  <= 1'b0;
      e_done  <= 1'b0;
      byte_v  <= 1'b0;
      sreg    <= '0;
      tx_cnt  <= '0;
      dm_cnt  <= '0;
      rx_cnt  <= '0;
      rx_hi   <= '0;
      rx_byte <= '0;
    end else begin
      e_done <= 1'b0;
      byte_v <= 1'b0;
      if (op_go) begin
        e_busy <= 1'b1;
        ph     <= PH_DRIVE;
        sreg   <= op_a4 ? {op_cmd, op_addr}
                        : {op_cmd, op_addr[23:0], 8'h00};
        tx_cnt <= op_raw ? CMD_NIBS : (op_a4 ? ADDR4_NIBS : ADDR3_NIBS);
        dm_cnt <= op_raw ? 8'h00 : 8'(DUMMY_BEATS);
        rx_cnt <= op_raw ? 16'h0000 : op_rd;
      end else if (e_busy && !e_hold) begin
        ph <= ph + 2'h1;
        if (ph == PH_SAMPLE) begin
          if (tx_cnt != '0) begin
            sreg   <= {sreg[35:0], 4'h0};
            tx_cnt <= tx_cnt - 4'h1;
          end else if (dm_cnt != '0) begin
            dm_cnt <= dm_cnt - 8'h01;
          end else if (rx_cnt != '0) begin
            rx_cnt <= rx_cnt - 16'h0001;
            if (!rx_cnt[0]) begin
              rx_hi <= sy.dq;
            end else begin
              rx_byte <= {rx_hi, sy.dq};
              byte_v  <= 1'b1;
            end
          end
          if (e_last) begin
            e_busy <= 1'b0;
            e_done <= 1'b1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drivers
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins.sclk  <= 1'b0;
      pins.dq    <= '0;
      pins.dq_oe <= '0;
      pins.cs_n  <= 4'hF;
      pins.cs_oe <= 4'h1;
      clk_oe     <= 1'b1;
    end else if (jtag_mode) begin
      clk_oe     <= 1'b0;
      pins.dq_oe <= '0;
      pins.cs_oe <= '0;
    end else begin
      clk_oe       <= 1'b1;
      pins.cs_oe   <= strap_done ? 4'hF : 4'h1;
      pins.cs_n[0] <= !(e_busy || op_go || state == ST_FWD);
      if (state == ST_USER || state == ST_FWD) begin
        pins.cs_n[3:1] <= USER_CS_N;
      end else begin
        pins.cs_n[3:1] <= 3'h7;
      end
      if (e_busy && !e_hold) begin
        if (ph == PH_DRIVE) begin
          pins.sclk  <= 1'b0;
          pins.dq    <= sreg[39:36];
          pins.dq_oe <= (tx_cnt != '0) ? 4'hF : 4'h0;
        end else if (ph == PH_RISE) begin
          pins.sclk <= 1'b1;
        end
      end else begin
        // idle or read stall: clock parked low
        pins.sclk  <= 1'b0;
        pins.dq_oe <= '0;
      end
    end
  end

  assign FLASH_CLK    = pins.sclk;
  assign FLASH_CLK_OE = clk_oe;
  assign FLASH_DQ_OUT = pins.dq;
  assign FLASH_DQ_OE  = pins.dq_oe;
  assign FLASH_CS_N   = pins.cs_n;
  assign FLASH_CS_OE  = pins.cs_oe;

  ////////////////////////////////////////////////////////////////////////
  // boot sequencer
  assign gap_ok = !e_busy && !op_go && pins.cs_n[0];
  assign ok_now = fw_ok || (byte_v && first && rx_byte == FW_MAGIC);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state      <= ST_STRAP;
      strap_cnt  <= '0;
      strap_done <= 1'b0;
      jtag_mode  <= 1'b0;
      fw_idx     <= '0;
      fw_ok      <= 1'b0;
      first      <= 1'b0;
      a4         <= 1'b0;
      CONF_DONE  <= 1'b0;
      CONF_ERR   <= 1'b0;
      op_go      <= 1'b0;
      op_cmd     <= '0;
      op_addr    <= '0;
      op_raw     <= 1'b0;
      op_a4      <= 1'b0;
      op_rd      <= '0;
      ack        <= 1'b0;
    end else begin
      op_go <= 1'b0;
      case (state)
        ST_STRAP: begin
          if (strap_cnt == 2'(STRAP_WAIT)) begin
            strap_done <= 1'b1;
            if (sy.strap == STRAP_JTAG) begin
              jtag_mode <= 1'b1;
              state     <= ST_HIZ;
            end else if (sy.strap == STRAP_AS_FAST
                      || sy.strap == STRAP_AS_NORM) begin
              state <= ST_FW_GO;
            end else begin
              state <= ST_HIZ;
            end
          end else begin
            strap_cnt <= strap_cnt + 2'h1;
          end
        end
        ST_HIZ: begin
          state <= ST_HIZ;
        end
        ST_FW_GO: begin
          if (gap_ok) begin
            op_go   <= 1'b1;
            op_cmd  <= CMD_READ;
            op_addr <= fw_base(fw_idx);
            op_a4   <= 1'b0;
            op_raw  <= 1'b0;
            op_rd   <= 16'(2 * FW_BYTES);
            first   <= 1'b1;
            fw_ok   <= 1'b0;
            state   <= ST_FW_RD;
          end
        end
        ST_FW_RD: begin
          if (byte_v && first) begin
            first <= 1'b0;
            fw_ok <= rx_byte == FW_MAGIC;
          end
          if (e_done) begin
            if (ok_now) begin
              state <= (FLASH_MBIT >= FLASH_4B_MBIT) ? ST_EN4_GO
                                                     : ST_BS_GO;
            end else if (fw_idx == 2'h3) begin
              state <= ST_FAIL;
            end else begin
              fw_idx <= fw_idx + 2'h1;
              state  <= ST_FW_GO;
            end
          end
        end
        ST_EN4_GO: begin
          if (gap_ok) begin
            op_go  <= 1'b1;
            op_cmd <= CMD_EN4B;
            op_raw <= 1'b1;
            state  <= ST_EN4_WT;
          end
        end
        ST_EN4_WT: begin
          if (e_done) begin
            a4    <= 1'b1;
            state <= ST_BS_GO;
          end
        end
        ST_BS_GO: begin
          if (gap_ok) begin
            op_go   <= 1'b1;
            op_cmd  <= CMD_READ;
            op_addr <= fw_base(fw_idx) + 32'(FW_BYTES);
            op_a4   <= a4;
            op_raw  <= 1'b0;
            op_rd   <= 16'(2 * BS_BYTES);
            state   <= ST_BS_RD;
          end
        end
        ST_BS_RD: begin
          if (e_done) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (!fifo_out_valid && !CFG_VALID) begin
            CONF_DONE <= 1'b1;
            state     <= ST_USER;
          end
        end
        ST_USER: begin
          if (sy.helper && sy.frame) begin
            state <= ST_FWD;
          end
        end
        ST_FWD: begin
          if (sy.req != ack && gap_ok == 1'b0 && !e_busy && !op_go) begin
            op_go  <= 1'b1;
            op_cmd <= lk_hold;
            op_raw <= 1'b1;
            ack    <= sy.req;
          end else if (!sy.frame && !e_busy && !op_go && sy.req == ack) begin
            state <= ST_USER;
          end
        end
        ST_FAIL: begin
          CONF_ERR <= 1'b1;
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bitstream FIFO and registered output stage
  assign fifo_in_valid  = byte_v && state == ST_BS_RD;
  assign fifo_out_ready = !CFG_VALID || CFG_READY;

  qsbl_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_b     (RST_B),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CFG_VALID <= 1'b0;
      CFG_DATA  <= '0;
    end else if (fifo_out_valid && fifo_out_ready) begin
      CFG_VALID <= 1'b1;
      CFG_DATA  <= fifo_out_data;
    end else if (CFG_READY) begin
      CFG_VALID <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: bytes from the programmer, handshake back
  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lk_ack_s1  <= 1'b0;
      lk_ack_s2  <= 1'b0;
      LINK_READY <= 1'b0;
    end else begin
      lk_ack_s1  <= ack;
      lk_ack_s2  <= lk_ack_s1;
      LINK_READY <= lk_req == lk_ack_s2;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lk_shift <= '0;
      lk_bcnt  <= '0;
      lk_hold  <= '0;
      lk_req   <= 1'b0;
    end else if (LINK_FRAME) begin
      lk_shift <= {lk_shift[5:0], LINK_DATA};
      lk_bcnt  <= lk_bcnt + 3'h1;
      if (lk_bcnt == 3'h7 && lk_req == lk_ack_s2) begin
        lk_hold <= {lk_shift, LINK_DATA};
        lk_req  <= !lk_req;
      end
    end
  end

endmodule // qsbl_loader

// *** test/qsbl_flash_model.sv ***
// qsbl_flash_model: behavioural quad serial flash on select 0
// assumes four-line commands and addresses, most significant nibble first
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module qsbl_flash_model
  import qsbl_pkg::*;
#(
  parameter int         DUMMY = 4,
  parameter logic [7:0] MAGIC = 8'hA5
)(
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] dq_oe,
  input  wire logic [3:0] dq_host,
  input  wire logic [2:0] fw_sect,
  output logic      [3:0] dq_dev
);
  logic [63:0] sh;
  int          hdr;
  int          rises;
  int          idx;
  logic [7:0]  rd_byte;
  logic [7:0]  cmd_log[$];
  logic [31:0] adr_log[$];
  int          nib_log[$];

  // image: check byte at the start of the chosen section
  function automatic logic [7:0] mem(input logic [31:0] a);
    return (a == {11'h0, fw_sect, 18'h0}) ? MAGIC : a[7:0];
  endfunction

  function automatic logic [31:0] adr_of();
    return 32'(sh & ((64'h1 << (4 * (hdr - 2))) - 64'h1));
  endfunction

  initial begin
    dq_dev = 4'h0;
    sh = '0;
    hdr = 0;
    rises = 0;
  end

  always @(negedge cs_n) begin
    sh = '0;
    hdr = 0;
    rises = 0;
  end

  // header nibbles are those the host drives on all four lines
  always @(posedge sclk) if (!cs_n) begin
    rises++;
    if (dq_oe == 4'hF) begin
      sh = {sh[59:0], dq_host};
      hdr++;
    end
  end

  always @(posedge cs_n) if (hdr >= 2) begin
    cmd_log.push_back(8'(sh >> (4 * (hdr - 2))));
    adr_log.push_back(adr_of());
    nib_log.push_back(hdr);
  end

  // read nibbles change after the falling clock; idle lines toggle
  always @(negedge sclk or posedge cs_n) begin
    idx = rises - hdr - DUMMY;
    rd_byte = mem(adr_of() + 32'(idx / 2));
    if (cs_n || hdr < 8 || idx < 0)
      dq_dev <= ~dq_dev;
    else
      dq_dev <= idx[0] ? rd_byte[3:0] : rd_byte[7:4];
  end
endmodule // qsbl_flash_model

// *** test/qsbl_loader_chk.sv ***
// qsbl_loader_chk: port-level properties of the boot loader
// assumes it is bound into every qsbl_loader instance
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module qsbl_loader_chk (
  input wire logic       SYS_CLK,
  input wire logic       RST_B,
  input wire logic       FLASH_CLK,
  input wire logic       FLASH_CLK_OE,
  input wire logic [3:0] FLASH_DQ_OE,
  input wire logic [3:0] FLASH_CS_N,
  input wire logic [3:0] FLASH_CS_OE,
  input wire logic       CONF_DONE,
  input wire logic       CONF_ERR,
  input wire logic [7:0] CFG_DATA,
  input wire logic       CFG_VALID,
  input wire logic       CFG_READY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  a_jtag_tristate: assert property (FLASH_CS_OE == 4'h0 |=>
    !FLASH_CLK_OE && FLASH_DQ_OE == 4'h0) else $error("pins driven in jtag");
  a_strap_wait: assert property ($rose(RST_B) |->
    (FLASH_CS_OE == 4'h1) [*4]) else $error("select enables too early");
  a_mode_kept: assert property (FLASH_CS_OE inside {4'h0, 4'hF} |=>
    $stable(FLASH_CS_OE)) else $error("mode changed after latch");
  a_extra_high: assert property (!CONF_DONE |->
    FLASH_CS_N[3:1] == 3'h7) else $error("extra select asserted");
  a_clk_beat: assert property ($rose(FLASH_CLK) |=>
    FLASH_CLK ##1 !FLASH_CLK) else $error("serial clock beat wrong");
  a_clk_sel: assert property (FLASH_CLK || FLASH_DQ_OE != 4'h0 |->
    !FLASH_CS_N[0]) else $error("flash driven while deselected");
  a_done_last: assert property ($rose(CONF_DONE) |->
    !CFG_VALID) else $error("done before stream drained");
  a_err_idle: assert property (CONF_ERR |->
    !CONF_DONE && FLASH_CS_N[0]) else $error("activity after failure");
  a_cfg_hold: assert property (CFG_VALID && !CFG_READY |=>
    CFG_VALID && $stable(CFG_DATA)) else $error("stream byte not held");
endmodule // qsbl_loader_chk

bind qsbl_loader qsbl_loader_chk chk_u (
  .SYS_CLK(SYS_CLK), .RST_B(RST_B), .FLASH_CLK(FLASH_CLK),
  .FLASH_CLK_OE(FLASH_CLK_OE), .FLASH_DQ_OE(FLASH_DQ_OE),
  .FLASH_CS_N(FLASH_CS_N), .FLASH_CS_OE(FLASH_CS_OE),
  .CONF_DONE(CONF_DONE), .CONF_ERR(CONF_ERR), .CFG_DATA(CFG_DATA),
  .CFG_VALID(CFG_VALID), .CFG_READY(CFG_READY));

// *** test/qsbl_loader_bench.sv ***
// qsbl_loader_bench: boot, failure, programmer mode and link forwarding
// assumes the flash model on select 0 and pulled select and clock pins
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module qsbl_loader_bench;
  import qsbl_pkg::*;
  logic        sys_clk = 0, rst_b = 0, helper_ok = 0, cfg_ready = 0;
  logic        link_clk = 0, link_frame = 0, link_data = 0;
  logic [2:0]  strap = 3'h1, user_cs_n = 3'h7, fw_sect = 3'h0;
  wire logic   flash_clk, clk_oe, conf_done, conf_err, cfg_valid, link_ready;
  wire logic [3:0] dq_out, dq_oe, cs_n, cs_oe, dq_dev, dq_in;
  wire logic [7:0] cfg_data;
  int          err_count = 0, n_compared = 0;
  logic [7:0]  rx_q[$];
  logic [31:0] bases[4] = '{FW_BASE_0, FW_BASE_1, FW_BASE_2, FW_BASE_3};

  always #50 sys_clk = ~sys_clk;
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & dq_dev);
  always @(posedge sys_clk) if (cfg_valid === 1'b1 && cfg_ready)
    rx_q.push_back(cfg_data);

  qsbl_loader dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .FLASH_CLK(flash_clk), .FLASH_CLK_OE(clk_oe), .FLASH_DQ_IN(dq_in),
    .FLASH_DQ_OUT(dq_out), .FLASH_DQ_OE(dq_oe), .FLASH_CS_N(cs_n),
    .FLASH_CS_OE(cs_oe), .STRAP_IN(strap), .USER_CS_N(user_cs_n),
    .HELPER_OK(helper_ok), .CONF_DONE(conf_done), .CONF_ERR(conf_err),
    .CFG_DATA(cfg_data), .CFG_VALID(cfg_valid), .CFG_READY(cfg_ready),
    .LINK_CLK(link_clk), .LINK_FRAME(link_frame), .LINK_DATA(link_data),
    .LINK_READY(link_ready));
  qsbl_flash_model flash_u (.sclk(clk_oe ? flash_clk : 1'b0),
    .cs_n(cs_oe[0] ? cs_n[0] : 1'b1), .dq_oe(dq_oe), .dq_host(dq_out),
    .fw_sect(fw_sect), .dq_dev(dq_dev));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic power_up(input logic [2:0] s, sect);
    rst_b = 0;
    strap = s;
    fw_sect = sect;
    cfg_ready = 0;
    helper_ok = 0;
    user_cs_n = 3'h7;
    cycles(20);
    // logs cleared after the reset closed any open session
    rx_q.delete();
    flash_u.cmd_log.delete();
    flash_u.adr_log.delete();
    flash_u.nib_log.delete();
    rst_b = 1;
  endtask
  task automatic wait_end();
    int i;
    for (i = 0; i < 8000 && conf_done !== 1'b1 && conf_err !== 1'b1; i++)
      cycles(1);
    if (i == 8000) begin
      err_count++;
      $display("ERROR %0t boot never ended", $time);
      test_done();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic boot_scn(input logic [2:0] s, sect);
    int r;
    power_up(s, sect);
    cycles(5);
    check(cs_oe, 4'hF, "select enables");
    strap = 3'h7;
    cycles(1200);
    r = flash_u.rises;
    cycles(40);
    check(flash_u.rises, r, "read stall on full buffer");
    cfg_ready = 1;
    wait_end();
    cycles(3);
    check(conf_done, 1'b1, "done");
    check(conf_err, 1'b0, "error");
    check(cs_n[3:1], 3'h7, "extra selects");
    for (int i = 0; i <= sect; i++) begin
      check(flash_u.cmd_log[i], CMD_READ, "fw cmd");
      check(flash_u.adr_log[i], bases[i], "fw base");
      check(flash_u.nib_log[i], 8, "fw header nibbles");
    end
    check(flash_u.cmd_log[sect + 1], CMD_EN4B, "four byte cmd");
    check(flash_u.nib_log[sect + 1], 2, "four byte nibbles");
    check(flash_u.cmd_log[sect + 2], CMD_READ, "stream cmd");
    check(flash_u.adr_log[sect + 2], bases[sect] + 16, "stream addr");
    check(flash_u.nib_log[sect + 2], 10, "stream header");
    check(rx_q.size(), 64, "stream length");
    for (int k = 0; k < 64; k++) check(rx_q[k], 16 + k, "stream byte");
  endtask
  task automatic link_byte(input logic [7:0] b);
    // exactly eight rises per byte; clock stopped while forwarding
    for (int i = 7; i >= 0; i--) begin
      link_data = b[i];
      #15 link_clk = 1;
      #15 link_clk = 0;
    end
    cycles(20);
  endtask
  task automatic fwd_scn();
    helper_ok = 1;
    user_cs_n = 3'h2;
    cycles(4);
    check(cs_n[3:1], 3'h2, "user selects");
    link_frame = 1;
    link_byte(8'h5A);
    link_byte(8'hC3);
    check(cs_n[0], 1'b0, "session select");
    link_frame = 0;
    #15 link_clk = 1;
    #15 link_clk = 0;
    check(link_ready, 1'b0, "ready while ack pending");
    repeat (2) begin
      #15 link_clk = 1;
      #15 link_clk = 0;
    end
    check(link_ready, 1'b1, "ready after ack");
    cycles(20);
    check(cs_n[0], 1'b1, "session closed");
    check(flash_u.hdr, 4, "forwarded nibbles");
    check(flash_u.sh[15:0], 16'h5AC3, "forwarded bytes");
  endtask
  task automatic err_scn();
    power_up(3'h1, 3'h4);
    cfg_ready = 1;
    wait_end();
    cycles(3);
    check(conf_err, 1'b1, "no firmware");
    check(conf_done, 1'b0, "no done");
    check(flash_u.cmd_log.size(), 4, "four tries");
    check(flash_u.adr_log[3], FW_BASE_3, "last try");
  endtask
  task automatic jtag_scn();
    power_up(3'h7, 3'h0);
    cycles(10);
    check(clk_oe, 1'b0, "clock enable");
    check(dq_oe, 4'h0, "data enables");
    check(cs_oe, 4'h0, "select enables");
    strap = 3'h1;
    cycles(300);
    check(cs_oe, 4'h0, "mode kept");
    check(flash_u.cmd_log.size(), 0, "no flash traffic");
  endtask

  initial begin
    boot_scn(3'h1, 3'h0);
    fwd_scn();
    boot_scn(3'h3, 3'h2);
    err_scn();
    jtag_scn();
    test_done();
  end
endmodule // qsbl_loader_bench
